//--- hw/toc_unit.sv
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module toc_unit
    import toc_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // tick sources: index is tick source selection, entry 0 unused
    input wire logic [7:1] tick_src,
    // port pins
    input wire logic [1:0] port_value,
    input wire logic [1:0] port_dir,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe,
    // interrupt requests: overflow, match a, match b
    output logic [2:0] irq_req
);
    // ************************************************************
    // state
    // ************************************************************
    logic [7:0] timer_count_value;
    logic [7:0] compare_value_a;
    logic [7:0] compare_value_b;
    logic [7:0] cmp_buf_a;
    logic [7:0] cmp_buf_b;
    logic [2:0] waveform_mode_sel;
    logic [2:0] tick_source_sel;
    logic [1:0] output_action_sel_a;
    logic [1:0] output_action_sel_b;
    logic [1:0] chan_output_state;
    logic overflow_flag;
    logic match_flag_a;
    logic match_flag_b;
    logic [2:0] irq_en;
    logic count_down;
    logic block_pend;
    logic [7:0] tick_meta;
    logic [7:0] tick_sync;
    logic [7:0] tick_prev;
    logic timer_tick;
    logic [1:0] match;
    logic is_pwm;
    logic at_max;
    logic at_bottom;
    logic [7:0] top_val;
    logic [7:0] next_count;
    logic next_down;
    logic update_pt;
    // ************************************************************
    // axi4-lite slave
    // ************************************************************
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic wr_fire;
    logic rd_fire;
    logic [31:0] rd_word;
    logic addr_ok;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    // capture address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end
    // write address decode
    always_comb begin
        case (aw_addr)
            TOC_ADDR_CTRL, TOC_ADDR_COUNT, TOC_ADDR_CMP_A, TOC_ADDR_CMP_B,
            TOC_ADDR_FLAGS, TOC_ADDR_IRQ_EN, TOC_ADDR_FORCE, TOC_ADDR_ISR_ACK: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= TOC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_ok ? TOC_RESP_OKAY : TOC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
    // write strobes per register (low bytes)
    logic wr_ctrl0;
    logic wr_ctrl1;
    logic wr_count;
    logic wr_cmp_a;
    logic wr_cmp_b;
    logic wr_flags;
    logic wr_irq_en;
    logic wr_force;
    logic wr_ack;
    assign wr_ctrl0 = wr_fire && aw_addr == TOC_ADDR_CTRL && w_strb[0];
    assign wr_ctrl1 = wr_fire && aw_addr == TOC_ADDR_CTRL && w_strb[1];
    assign wr_count = wr_fire && aw_addr == TOC_ADDR_COUNT && w_strb[0];
    assign wr_cmp_a = wr_fire && aw_addr == TOC_ADDR_CMP_A && w_strb[0];
    assign wr_cmp_b = wr_fire && aw_addr == TOC_ADDR_CMP_B && w_strb[0];
    assign wr_flags = wr_fire && aw_addr == TOC_ADDR_FLAGS && w_strb[0];
    assign wr_irq_en = wr_fire && aw_addr == TOC_ADDR_IRQ_EN && w_strb[0];
    assign wr_force = wr_fire && aw_addr == TOC_ADDR_FORCE && w_strb[0];
    assign wr_ack = wr_fire && aw_addr == TOC_ADDR_ISR_ACK && w_strb[0];
    // read mux; compare reads follow the buffering mode
    always_comb begin
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            TOC_ADDR_CTRL: begin
                rd_word[TOC_CTRL_WGM_LSB +: 3] = waveform_mode_sel;
                rd_word[TOC_CTRL_TSS_LSB +: 3] = tick_source_sel;
                rd_word[TOC_CTRL_COMA_LSB +: 2] = output_action_sel_a;
                rd_word[TOC_CTRL_COMB_LSB +: 2] = output_action_sel_b;
            end
            TOC_ADDR_COUNT: rd_word[7:0] = timer_count_value;
            TOC_ADDR_CMP_A: rd_word[7:0] = is_pwm ? cmp_buf_a : compare_value_a;
            TOC_ADDR_CMP_B: rd_word[7:0] = is_pwm ? cmp_buf_b : compare_value_b;
            TOC_ADDR_FLAGS: begin
                rd_word[TOC_BIT_OVF] = overflow_flag;
                rd_word[TOC_BIT_MA] = match_flag_a;
                rd_word[TOC_BIT_MB] = match_flag_b;
            end
            TOC_ADDR_IRQ_EN: rd_word[2:0] = irq_en;
            TOC_ADDR_FORCE, TOC_ADDR_ISR_ACK: rd_word = 32'h0000_0000;
            default: rd_word = 32'h0000_0000;
        endcase
    end
    // read response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= TOC_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (s_axi_araddr <= TOC_ADDR_ISR_ACK && s_axi_araddr[1:0] == 2'b00) ?
                TOC_RESP_OKAY : TOC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    // ************************************************************
    // control registers
    // ************************************************************
    // mode, tick source and output-action fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            waveform_mode_sel <= TOC_WGM_NORMAL;
            tick_source_sel <= TOC_TSS_STOP;
            output_action_sel_a <= TOC_COM_NONE;
            output_action_sel_b <= TOC_COM_NONE;
            irq_en <= 3'h0;
        end else begin
            if (wr_ctrl0) begin
                waveform_mode_sel <= w_data[TOC_CTRL_WGM_LSB +: 3];
                tick_source_sel <= w_data[TOC_CTRL_TSS_LSB +: 3];
            end
            if (wr_ctrl1) begin // unbuffered
                output_action_sel_a <= w_data[TOC_CTRL_COMA_LSB +: 2];
                output_action_sel_b <= w_data[TOC_CTRL_COMB_LSB +: 2];
            end
            if (wr_irq_en) begin
                irq_en <= w_data[2:0];
            end
        end
    end
    // ************************************************************
    // timer tick from selected source
    // ************************************************************
    // two-stage sync then rising-edge detect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_meta <= 8'h00;
            tick_sync <= 8'h00;
            tick_prev <= 8'h00;
        end else begin
            tick_meta <= {tick_src, 1'b0};
            tick_sync <= tick_meta;
            tick_prev <= tick_sync;
        end
    end
    // source zero yields no tick
    assign timer_tick = (tick_source_sel != TOC_TSS_STOP) &&
        tick_sync[tick_source_sel] && !tick_prev[tick_source_sel];
    // ************************************************************
    // counter unit
    // ************************************************************
    assign is_pwm = waveform_mode_sel[0];
    assign at_max = timer_count_value == TOC_COUNT_MAX;
    assign at_bottom = timer_count_value == TOC_COUNT_BOTTOM;
    assign top_val = waveform_mode_sel[2] ? compare_value_a : TOC_COUNT_MAX;
    // next count depends on waveform mode, count, direction and compare a
    always_comb begin
        next_count = timer_count_value + 8'h01;
        next_down = count_down;
        update_pt = 1'b0;
        case (waveform_mode_sel)
            TOC_WGM_CTC: begin
                if (match[0]) next_count = TOC_COUNT_BOTTOM;
            end
            TOC_WGM_FAST_FF, TOC_WGM_FAST_OCR: begin
                if (timer_count_value == top_val) begin
                    next_count = TOC_COUNT_BOTTOM;
                    update_pt = 1'b1;
                end
            end
            TOC_WGM_PC_FF, TOC_WGM_PC_OCR: begin
                if (timer_count_value == top_val) begin
                    next_down = 1'b1;
                    next_count = timer_count_value - 8'h01;
                    update_pt = 1'b1;
                end else if (count_down && at_bottom) begin
                    next_down = 1'b0;
                end else if (count_down) begin
                    next_count = timer_count_value - 8'h01;
                end
            end
            default: next_count = timer_count_value + 8'h01;
        endcase
    end
    // count with cpu write priority
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_count_value <= TOC_COUNT_RST;
            count_down <= 1'b0;
        end else if (wr_count) begin
            timer_count_value <= w_data[7:0];
        end else if (timer_tick) begin
            timer_count_value <= next_count;
            count_down <= is_pwm ? next_down : 1'b0;
        end
    end
    // cpu write lands whatever the tick does
    property p_count_write_wins;
        @(posedge aclk) disable iff (!aresetn) wr_count |=> timer_count_value == w_data[7:0];
    endproperty
    a_count_write_wins: assert property (p_count_write_wins) else $error("count write lost");
    // normal mode steps up by one, wrapping at max
    property p_normal_step;
        @(posedge aclk) disable iff (!aresetn)
            timer_tick && !wr_count && waveform_mode_sel == TOC_WGM_NORMAL |=>
            timer_count_value == $past(timer_count_value) + 8'h01;
    endproperty
    a_normal_step: assert property (p_normal_step) else $error("normal count step wrong");
    // stopped timer keeps its count unless written
    property p_stopped_hold;
        @(posedge aclk) disable iff (!aresetn)
            tick_source_sel == TOC_TSS_STOP && !wr_count |=> $stable(timer_count_value);
    endproperty
    a_stopped_hold: assert property (p_stopped_hold) else $error("stopped count moved");
    // ************************************************************
    // compare registers
    // ************************************************************
    // buffered in pwm modes, direct otherwise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_value_a <= TOC_CMP_RST;
            compare_value_b <= TOC_CMP_RST;
            cmp_buf_a <= TOC_CMP_RST;
            cmp_buf_b <= TOC_CMP_RST;
        end else begin
            if (wr_cmp_a) cmp_buf_a <= w_data[7:0];
            if (wr_cmp_b) cmp_buf_b <= w_data[7:0];
            if (!is_pwm) begin
                if (wr_cmp_a) compare_value_a <= w_data[7:0];
                if (wr_cmp_b) compare_value_b <= w_data[7:0];
            end else if (timer_tick && (update_pt ||
                        (count_down && at_bottom))) begin
                compare_value_a <= cmp_buf_a;
                compare_value_b <= cmp_buf_b;
            end
        end
    end
    // ************************************************************
    // comparator and match blocking
    // ************************************************************
    // active registers only
    assign match[0] = timer_count_value == compare_value_a;
    assign match[1] = timer_count_value == compare_value_b;
    // block armed by count write, cleared by next tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            block_pend <= 1'b0;
        end else if (wr_count) begin
            block_pend <= 1'b1;
        end else if (timer_tick) begin
            block_pend <= 1'b0;
        end
    end
    // match held through a count cycle acts at the tick ending it
    logic [1:0] match_hit;
    assign match_hit = (timer_tick && !block_pend && !wr_count) ? match : 2'b00;
    // ************************************************************
    // flags
    // ************************************************************
    logic ovf_set;
    logic [1:0] flag_set;
    assign ovf_set = timer_tick && !wr_count && next_count == TOC_COUNT_BOTTOM &&
        at_max && !is_pwm;
    assign flag_set = match_hit;
    // set wins over software or service clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag <= 1'b0;
            match_flag_a <= 1'b0;
            match_flag_b <= 1'b0;
        end else begin
            if (ovf_set) overflow_flag <= 1'b1;
            else if ((wr_flags && w_data[TOC_BIT_OVF]) || (wr_ack && w_data[TOC_BIT_OVF]))
                overflow_flag <= 1'b0;
            if (flag_set[0]) match_flag_a <= 1'b1;
            else if ((wr_flags && w_data[TOC_BIT_MA]) || (wr_ack && w_data[TOC_BIT_MA]))
                match_flag_a <= 1'b0;
            if (flag_set[1]) match_flag_b <= 1'b1;
            else if ((wr_flags && w_data[TOC_BIT_MB]) || (wr_ack && w_data[TOC_BIT_MB]))
                match_flag_b <= 1'b0;
        end
    end
    // match at a tick raises the flag
    property p_match_sets_flag;
        @(posedge aclk) disable iff (!aresetn) match_hit[0] |=> match_flag_a;
    endproperty
    a_match_sets_flag: assert property (p_match_sets_flag) else $error("match flag not set");
    // forcing never raises the flag
    property p_force_no_flag;
        @(posedge aclk) disable iff (!aresetn) force_hit[0] && !timer_tick && !match_flag_a |=> !match_flag_a;
    endproperty
    a_force_no_flag: assert property (p_force_no_flag) else $error("force raised flag");
    // writing one clears the flag
    property p_flag_clear;
        @(posedge aclk) disable iff (!aresetn)
            wr_flags && w_data[TOC_BIT_MA] && !flag_set[0] |=> !match_flag_a;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
    // gated requests
    assign irq_req = irq_en & {match_flag_b, match_flag_a, overflow_flag};
    // ************************************************************
    // waveform generator and pin override
    // ************************************************************
    logic [1:0] force_hit;
    assign force_hit = (wr_force && !is_pwm) ? w_data[1:0] : 2'b00;
    // per-channel output state, kept across mode changes
    function automatic logic wave_next(input logic st, input logic [1:0] act, input logic pwm,
                                       input logic down, input logic bot);
        logic r;
        r = st;
        if (!pwm) begin
            case (act)
                TOC_COM_TOGGLE: r = !st;
                TOC_COM_CLEAR: r = 1'b0;
                TOC_COM_SET: r = 1'b1;
                default: r = st;
            endcase
        end else if (act[1]) begin
            r = act[0] ^ (bot ? 1'b1 : down);
        end
        return r;
    endfunction
    logic [1:0] act_sel [2];
    assign act_sel[0] = output_action_sel_a;
    assign act_sel[1] = output_action_sel_b;
    genvar gi;
    for (gi = 0; gi < 2; gi++) begin : g_chan
        logic fast_bot;
        logic out_q;
        assign fast_bot = is_pwm && !waveform_mode_sel[1] ? 1'b0 :
            (is_pwm && timer_tick && update_pt);
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                out_q <= 1'b0;
            end else if (force_hit[gi] || match_hit[gi]) begin
                out_q <= wave_next(out_q, act_sel[gi], is_pwm && !force_hit[gi], count_down, 1'b0);
            end else if (fast_bot && act_sel[gi][1]) begin
                out_q <= !act_sel[gi][0];
            end
        end
        assign chan_output_state[gi] = out_q;
        // override on nonzero action, any mode
        assign pin_out[gi] = (act_sel[gi] != TOC_COM_NONE) ? chan_output_state[gi] : port_value[gi];
        assign pin_oe[gi] = port_dir[gi];
    end
    // reset leaves both output states low
    property p_state_reset;
        @(posedge aclk) !aresetn |=> chan_output_state == 2'b00;
    endproperty
    a_state_reset: assert property (p_state_reset) else $error("output state not reset");
endmodule : toc_unit
`default_nettype wire

//--- hw/toc_pkg.sv
package toc_pkg;
    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] TOC_ADDR_CTRL = 8'h00;
    localparam logic [7:0] TOC_ADDR_COUNT = 8'h04;
    localparam logic [7:0] TOC_ADDR_CMP_A = 8'h08;
    localparam logic [7:0] TOC_ADDR_CMP_B = 8'h0C;
    localparam logic [7:0] TOC_ADDR_FLAGS = 8'h10;
    localparam logic [7:0] TOC_ADDR_IRQ_EN = 8'h14;
    localparam logic [7:0] TOC_ADDR_FORCE = 8'h18;
    localparam logic [7:0] TOC_ADDR_ISR_ACK = 8'h1C;
    // ************************************************************
    // control register field positions
    // ************************************************************
    localparam int TOC_CTRL_WGM_LSB = 0;
    localparam int TOC_CTRL_TSS_LSB = 4;
    localparam int TOC_CTRL_COMA_LSB = 8;
    localparam int TOC_CTRL_COMB_LSB = 10;
    // ************************************************************
    // flag and enable bit positions
    // ************************************************************
    localparam int TOC_BIT_OVF = 0;
    localparam int TOC_BIT_MA = 1;
    localparam int TOC_BIT_MB = 2;
    // ************************************************************
    // values
    // ************************************************************
    localparam logic [7:0] TOC_COUNT_MAX = 8'hFF;
    localparam logic [7:0] TOC_COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] TOC_COUNT_RST = 8'h00;
    localparam logic [7:0] TOC_CMP_RST = 8'h00;
    localparam logic [2:0] TOC_TSS_STOP = 3'h0;
    localparam logic [1:0] TOC_RESP_OKAY = 2'h0;
    localparam logic [1:0] TOC_RESP_SLVERR = 2'h2;
    // ************************************************************
    // waveform modes
    // ************************************************************
    typedef enum logic [2:0] {
        TOC_WGM_NORMAL = 3'b000,
        TOC_WGM_PC_FF = 3'b001,
        TOC_WGM_CTC = 3'b010,
        TOC_WGM_FAST_FF = 3'b011,
        TOC_WGM_RSVD4 = 3'b100,
        TOC_WGM_PC_OCR = 3'b101,
        TOC_WGM_RSVD6 = 3'b110,
        TOC_WGM_FAST_OCR = 3'b111
    } toc_wgm_e;
    // output-action codes in non-pwm modes
    localparam logic [1:0] TOC_COM_NONE = 2'h0;
    localparam logic [1:0] TOC_COM_TOGGLE = 2'h1;
    localparam logic [1:0] TOC_COM_CLEAR = 2'h2;
    localparam logic [1:0] TOC_COM_SET = 2'h3;
endpackage : toc_pkg

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// bench signals and bus tasks
// ************************************************************
module tb_top
    import toc_pkg::*;
;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs, port_value, port_dir, pin_out, pin_oe;
    logic [7:1] tick_src;
    logic [2:0] irq_req;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    toc_unit u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tick_src(tick_src),
        .port_value(port_value), .port_dir(port_dir), .pin_out(pin_out), .pin_oe(pin_oe), .irq_req(irq_req));
    // 25 mhz clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // each channel held until taken at a rising edge, answer taken at the edge it is seen
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask : axi_rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk({30'h0, r}, {30'h0, TOC_RESP_OKAY}, "write response");
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        axi_rd(a, rd, rs);
        chk(rd, exp, what);
    endtask : rd_chk
    // one timer tick per pulse on source 1
    task automatic tick(input int n);
        repeat (n) begin
            tick_src[1] <= 1'b1;
            repeat (4) @(posedge aclk);
            tick_src[1] <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask : tick
// ************************************************************
// test sequence
// ************************************************************
    initial begin
        {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata, tick_src} = '0;
        {bready, rready, wstrb, port_value, port_dir} = {2'b11, 4'hF, 2'b10, 2'b00};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(TOC_ADDR_CTRL, 32'h0000_0000, "ctrl reset");
        rd_chk(TOC_ADDR_FLAGS, 32'h0000_0000, "flags reset");
        axi_rd(8'h20, rd, rs);
        chk({30'h0, rs}, {30'h0, TOC_RESP_SLVERR}, "unmapped read");
        axi_wr(8'h20, 32'h0000_0001, rs);
        chk({30'h0, rs}, {30'h0, TOC_RESP_SLVERR}, "unmapped write");
        wr(TOC_ADDR_COUNT, 32'h0000_00FE);
        wr(TOC_ADDR_CMP_B, 32'h0000_0003);
        wr(TOC_ADDR_CMP_A, 32'h0000_0005);
        rd_chk(TOC_ADDR_CMP_A, 32'h0000_0005, "compare a readback");
        wr(TOC_ADDR_CTRL, 32'h0000_0110);
        chk({30'h0, pin_out}, 32'h0000_0002, "pins after reset");
        chk({30'h0, pin_oe}, 32'h0000_0000, "pin direction");
        port_dir <= 2'b10;
        @(posedge aclk);
        @(posedge aclk);
        chk({30'h0, pin_oe}, 32'h0000_0002, "pin direction b");
        tick(2);
        rd_chk(TOC_ADDR_COUNT, 32'h0000_0000, "count wrap");
        rd_chk(TOC_ADDR_FLAGS, 32'h0000_0001, "overflow flag");
        wr(TOC_ADDR_CMP_A, 32'h0000_0001);
        tick(2);
        rd_chk(TOC_ADDR_FLAGS, 32'h0000_0003, "match a flag");
        chk({30'h0, pin_out}, 32'h0000_0003, "toggle at match");
        wr(TOC_ADDR_FLAGS, 32'h0000_0002);
        rd_chk(TOC_ADDR_FLAGS, 32'h0000_0001, "one clears");
        wr(TOC_ADDR_FLAGS, 32'h0000_0000);
        rd_chk(TOC_ADDR_FLAGS, 32'h0000_0001, "zero keeps");
        wr(TOC_ADDR_IRQ_EN, 32'h0000_0007);
        chk({29'h0, irq_req}, 32'h0000_0001, "overflow request");
        wr(TOC_ADDR_ISR_ACK, 32'h0000_0001);
        rd_chk(TOC_ADDR_FLAGS, 32'h0000_0000, "service clears");
        wr(TOC_ADDR_CTRL, 32'h0000_0210);
        wr(TOC_ADDR_FORCE, 32'h0000_0001);
        chk({30'h0, pin_out}, 32'h0000_0002, "forced clear");
        port_dir <= 2'b11;
        @(posedge aclk);
        chk({30'h0, pin_oe}, 32'h0000_0003, "output enabled after init");
        rd_chk(TOC_ADDR_FLAGS, 32'h0000_0000, "force sets no flag");
        rd_chk(TOC_ADDR_COUNT, 32'h0000_0002, "force keeps count");
        wr(TOC_ADDR_COUNT, 32'h0000_0001);
        tick(3);
        rd_chk(TOC_ADDR_FLAGS, 32'h0000_0004, "match blocked after write");
        chk({29'h0, irq_req}, 32'h0000_0004, "match b request");
        rd_chk(TOC_ADDR_COUNT, 32'h0000_0004, "count after write");
        wr(TOC_ADDR_CTRL, 32'h0000_0310);
        wr(TOC_ADDR_FORCE, 32'h0000_0001);
        chk({30'h0, pin_out}, 32'h0000_0003, "forced set");
        wr(TOC_ADDR_CTRL, 32'h0000_0113);
        chk({30'h0, pin_out}, 32'h0000_0003, "state kept in pwm mode");
        wr(TOC_ADDR_CMP_A, 32'h0000_0040);
        rd_chk(TOC_ADDR_CMP_A, 32'h0000_0040, "buffer read in pwm");
        wr(TOC_ADDR_CTRL, 32'h0000_0010);
        chk({30'h0, pin_out}, 32'h0000_0002, "port value without action");
        rd_chk(TOC_ADDR_CMP_A, 32'h0000_0001, "active kept without top");
        wr(TOC_ADDR_CMP_A, 32'h0000_0005);
        tick(2);
        wr(TOC_ADDR_CTRL, 32'h0000_0110);
        chk({30'h0, pin_out}, 32'h0000_0003, "no action at match");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
